// ==== core/tcc_cfg.svh ====
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
// ************************************************************
// status word fields
// ************************************************************
`define TCC_CU_HI     31
`define TCC_CU_LO     28
`define TCC_CU1       1
`define TCC_DSP       27
`define TCC_FR        26
`define TCC_RS_HI     24
`define TCC_RS_LO     23
`define TCC_DS        21
`define TCC_DT        20
`define TCC_CEE       17
`define TCC_DA        15
`define TCC_ACT       13
`define TCC_PRIV_HI   12
`define TCC_PRIV_LO   11
`define TCC_IX        10
`define TCC_ASID_HI   7
`define TCC_ASID_LO   0
// ************************************************************
// binding word fields
// ************************************************************
`define TCC_ID_HI     28
`define TCC_ID_LO     21
`define TCC_TBE       17
`define TCC_VP_HI     3
`define TCC_VP_LO     0
// ************************************************************
// reset values
// ************************************************************
`define TCC_RST_CU    4'h0
`define TCC_RST_PRIV  2'h0
`define TCC_RST_ASID  8'h00
`define TCC_RST_PC    32'h00000000
`define TCC_RST_WORD  32'h00000000
`define TCC_VP0       4'h0
`define TCC_VP1       4'h1
`endif

// ==== core/tcc_pkg.sv ====
package tcc_pkg;
  // register select of the coprocessor move
  typedef enum logic [1:0] {
    SEL_STATUS,
    SEL_BIND,
    SEL_RESTART,
    SEL_NONE
  } tcc_sel_t;
  // run state encoding
  typedef enum logic [1:0] {
    RS_RUNNING,
    RS_WAIT,
    RS_SUSPEND,
    RS_GATING
  } tcc_run_t;
endpackage

// ==== core/tcc_regs.sv ====
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_regs
  import tcc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // configuration
  input  wire logic        fpu_present,
  input  wire logic        fpu_multithread,
  input  wire logic        dsp_present,
  input  wire logic        tlb_present,
  input  wire logic        compressed_present,
  input  wire logic        is_thread0,
  input  wire logic [7:0]  own_thread_id,
  input  wire logic [3:0]  vproc0_last_thread_input,
  input  wire logic        vproc_config_enable,
  input  wire logic        other_thread_holds_cu1,
  // coprocessor move access
  input  wire tcc_sel_t    reg_sel,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_rvalid,
  // global status and entry-high views
  input  wire logic        gstat_wr,
  input  wire logic [3:0]  gstat_cu,
  input  wire logic        gstat_dsp,
  input  wire logic        gstat_fr,
  input  wire logic        gstat_cee,
  input  wire logic [1:0]  gstat_priv,
  input  wire logic        entryhi_wr,
  input  wire logic [7:0]  entryhi_asid,
  // thread events
  input  wire logic        halted,
  input  wire tcc_run_t    run_state_in,
  input  wire logic        retire,
  input  wire logic        retire_privileged,
  input  wire logic        spawn,
  input  wire logic [1:0]  spawn_priv,
  input  wire logic [7:0]  spawn_asid,
  input  wire logic        suspend_dealloc,
  input  wire logic        halt_event,
  input  wire logic [31:0] halt_next_pc,
  input  wire logic        halt_isa_mode,
  input  wire logic        halt_in_delay_slot,
  input  wire logic [31:0] halt_branch_pc,
  input  wire logic        load_bus_error,
  // thread state out
  output logic      [3:0]  thread_coproc_usable,
  output logic             thread_dsp_enable,
  output logic             thread_fp_reg_mode,
  output logic             thread_core_ext_enable,
  output logic      [1:0]  thread_privilege,
  output logic      [7:0]  thread_addr_space_id,
  output logic      [3:0]  vproc_affiliation,
  output logic             activated,
  output logic             dyn_alloc_ok,
  output logic             irq_eligible,
  output logic      [31:0] resume_pc,
  output logic             resume_isa,
  output logic             ll_cancel
);

  // ************************************************************
  // storage
  // ************************************************************
  logic [3:0]  cu_ff;
  logic        dsp_ff;
  logic        fr_ff;
  tcc_run_t    rs_ff;
  logic        ds_ff;
  logic        dirty_ff;
  logic        cee_ff;
  logic        da_ff;
  logic        act_ff;
  logic [1:0]  priv_ff;
  logic        ix_ff;
  logic [7:0]  asid_ff;
  logic        tbe_ff;
  logic [3:0]  vp_ff;
  logic [31:0] restart_ff;
  logic [31:0] rdata_ff;
  logic        rvalid_ff;

  // ************************************************************
  // decode
  // ************************************************************
  wire st_wr = reg_wr && (reg_sel == SEL_STATUS);
  wire bd_wr = reg_wr && (reg_sel == SEL_BIND);
  wire rp_wr = reg_wr && (reg_sel == SEL_RESTART);
  wire spawn_ok = spawn && da_ff && !halted;
  wire dealloc_ok = suspend_dealloc && da_ff && !halted;
  wire dirty_set = (retire && !retire_privileged) || spawn_ok;

  // value written through either view; status view wins
  wire [3:0] cu_w = st_wr ? reg_wdata[`TCC_CU_HI:`TCC_CU_LO] : gstat_cu;
  wire       any_cu = st_wr || gstat_wr;
  wire       cu1_ok = fpu_present && (fpu_multithread || !other_thread_holds_cu1 || cu_ff[`TCC_CU1]);
  wire [3:0] nxt_cu = {cu_w[3:2], cu_w[`TCC_CU1] && cu1_ok, cu_w[0]};
  wire       dsp_w = st_wr ? reg_wdata[`TCC_DSP] : gstat_dsp;
  wire       nxt_dsp = dsp_present ? dsp_w : 1'b0;
  wire       nxt_fr = st_wr ? reg_wdata[`TCC_FR] : gstat_fr;
  wire       nxt_cee = st_wr ? reg_wdata[`TCC_CEE] : gstat_cee;
  wire [1:0] priv_w = st_wr ? reg_wdata[`TCC_PRIV_HI:`TCC_PRIV_LO] : gstat_priv;
  wire [7:0] asid_w = st_wr ? reg_wdata[`TCC_ASID_HI:`TCC_ASID_LO] : entryhi_asid;
  wire       asid_upd = tlb_present && (st_wr || entryhi_wr);

  // halt capture picks branch while delay slot is pending
  wire [31:0] halt_pc = halt_in_delay_slot ? halt_branch_pc : halt_next_pc;
  wire [31:0] nxt_restart = {halt_pc[31:1], compressed_present && halt_isa_mode};

  wire [3:0] vp_reset = (own_thread_id <= {4'h0, vproc0_last_thread_input}) ? `TCC_VP0 : `TCC_VP1;

  // ************************************************************
  // read assembly
  // ************************************************************
  function automatic logic [31:0] status_word(input logic [3:0] cu, input logic [7:0] flg,
                                              input tcc_run_t rs, input logic [1:0] priv, input logic [7:0] asid);
    logic [31:0] w;
    w = `TCC_RST_WORD;
    w[`TCC_CU_HI:`TCC_CU_LO] = cu;
    w[`TCC_DSP] = flg[7];
    w[`TCC_FR] = flg[6];
    w[`TCC_RS_HI:`TCC_RS_LO] = rs;
    w[`TCC_DS] = flg[5];
    w[`TCC_DT] = flg[4];
    w[`TCC_CEE] = flg[3];
    w[`TCC_DA] = flg[2];
    w[`TCC_ACT] = flg[1];
    w[`TCC_PRIV_HI:`TCC_PRIV_LO] = priv;
    w[`TCC_IX] = flg[0];
    w[`TCC_ASID_HI:`TCC_ASID_LO] = asid;
    return w;
  endfunction
  function automatic logic [31:0] bind_word(input logic [7:0] id, input logic thread_bus_error, input logic [3:0] vp);
    logic [31:0] w;
    w = `TCC_RST_WORD;
    w[`TCC_ID_HI:`TCC_ID_LO] = id;
    w[`TCC_TBE] = thread_bus_error;
    w[`TCC_VP_HI:`TCC_VP_LO] = vp;
    return w;
  endfunction

  wire [7:0]  flag_bits = {dsp_ff, fr_ff, ds_ff, dirty_ff, cee_ff, da_ff, act_ff, ix_ff};
  wire [31:0] rd_mux = (reg_sel == SEL_STATUS)  ? status_word(cu_ff, flag_bits, rs_ff, priv_ff, asid_ff) :
                       (reg_sel == SEL_BIND)    ? bind_word(own_thread_id, tbe_ff, vp_ff) :
                       (reg_sel == SEL_RESTART) ? restart_ff : `TCC_RST_WORD;

  // ************************************************************
  // shared status fields
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      cu_ff <= `TCC_RST_CU;
      dsp_ff <= 1'b0;
      fr_ff <= 1'b0;
      cee_ff <= 1'b0;
    end else if (any_cu) begin
      cu_ff <= nxt_cu;
      dsp_ff <= nxt_dsp;
      fr_ff <= nxt_fr;
      cee_ff <= nxt_cee;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      priv_ff <= `TCC_RST_PRIV;
    end else if (spawn_ok) begin
      priv_ff <= spawn_priv;
    end else if (any_cu) begin
      priv_ff <= priv_w;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      asid_ff <= `TCC_RST_ASID;
    end else if (!tlb_present) begin
      asid_ff <= `TCC_RST_ASID;
    end else if (spawn_ok) begin
      asid_ff <= spawn_asid;
    end else if (asid_upd) begin
      asid_ff <= asid_w;
    end
  end

  // ************************************************************
  // thread-only status fields
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      rs_ff <= RS_RUNNING;
    end else if (!halted) begin
      rs_ff <= run_state_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ds_ff <= 1'b0;
    end else if (halt_event) begin
      ds_ff <= halt_in_delay_slot;
    end else if (rp_wr) begin
      ds_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dirty_ff <= 1'b0;
    end else if (dirty_set) begin
      dirty_ff <= 1'b1;
    end else if (st_wr) begin
      dirty_ff <= reg_wdata[`TCC_DT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      da_ff <= 1'b0;
      ix_ff <= 1'b0;
    end else if (st_wr) begin
      da_ff <= reg_wdata[`TCC_DA];
      ix_ff <= reg_wdata[`TCC_IX];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      act_ff <= is_thread0;
    end else if (spawn_ok) begin
      act_ff <= 1'b1;
    end else if (dealloc_ok) begin
      act_ff <= 1'b0;
    end else if (st_wr) begin
      act_ff <= reg_wdata[`TCC_ACT];
    end
  end

  // ************************************************************
  // binding fields
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      tbe_ff <= 1'b0;
    end else if (load_bus_error) begin
      tbe_ff <= 1'b1;
    end else if (bd_wr) begin
      tbe_ff <= reg_wdata[`TCC_TBE];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vp_ff <= vp_reset;
    end else if (bd_wr && vproc_config_enable) begin
      vp_ff <= reg_wdata[`TCC_VP_HI:`TCC_VP_LO];
    end
  end

  // ************************************************************
  // restart address
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      restart_ff <= `TCC_RST_PC;
    end else if (halt_event) begin
      restart_ff <= nxt_restart;
    end else if (rp_wr) begin
      restart_ff <= reg_wdata;
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= `TCC_RST_WORD;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
      if (reg_rd) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign thread_coproc_usable = cu_ff;
  assign thread_dsp_enable = dsp_ff;
  assign thread_fp_reg_mode = fr_ff;
  assign thread_core_ext_enable = cee_ff;
  assign thread_privilege = priv_ff;
  assign thread_addr_space_id = asid_ff;
  assign vproc_affiliation = vp_ff;
  assign activated = act_ff;
  assign dyn_alloc_ok = da_ff && !halted;
  assign irq_eligible = act_ff && !halted && !ix_ff;
  assign resume_pc = {restart_ff[31:1], 1'b0};
  assign resume_isa = compressed_present && restart_ff[0];
  assign ll_cancel = rp_wr;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_cu_global_view: assert property (gstat_wr && !st_wr |=>
    thread_coproc_usable[3:2] == $past(gstat_cu[3:2]))
    else $error("usable bits not shared with global view");
  a_cu1_no_fpu: assert property (!fpu_present && !$past(fpu_present) |->
    !thread_coproc_usable[`TCC_CU1])
    else $error("usable-1 set without fpu");
  a_dsp_ro: assert property (!dsp_present && !$past(dsp_present) |-> !thread_dsp_enable)
    else $error("dsp enable set without dsp");
  a_run_state_hold: assert property ($past(halted) && halted |-> $stable(rs_ff))
    else $error("run state moved while halted");
  a_delay_slot_halt: assert property (halt_event |=>
    ds_ff == $past(halt_in_delay_slot) && restart_ff[31:1] == $past(halt_pc[31:1]))
    else $error("delay slot capture wrong");
  a_dirty_retire: assert property (retire && !retire_privileged |=> dirty_ff)
    else $error("dirty not set on retire");
  a_spawn_activate: assert property (spawn_ok |=> activated ##1 1'b1)
    else $error("spawn did not activate");
  a_spawn_priv: assert property (spawn_ok |=> thread_privilege == $past(spawn_priv))
    else $error("privilege not copied on spawn");
  a_exempt_irq: assert property (ix_ff |-> !irq_eligible)
    else $error("exempt thread eligible for interrupt");
  a_bus_error: assert property (load_bus_error |=> tbe_ff)
    else $error("bus error not recorded");
  a_restart_raw: assert property (rp_wr && !halt_event ##1 !rp_wr && !halt_event ##1
    reg_rd && reg_sel == SEL_RESTART |=> reg_rdata == $past(reg_wdata, 3))
    else $error("restart read back altered");
  a_halted_alloc: assert property (halted |-> !dyn_alloc_ok)
    else $error("halted thread allocatable");
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
  import tcc_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  localparam logic [7:0] TID = 8'h05;
  localparam logic [3:0] BND = 4'h3;
  localparam logic [6:0] EV_RET = 7'h01;
  localparam logic [6:0] EV_SPN = 7'h02;
  localparam logic [6:0] EV_SUS = 7'h04;
  localparam logic [6:0] EV_HLT = 7'h08;
  localparam logic [6:0] EV_BUS = 7'h10;
  localparam logic [6:0] EV_GST = 7'h20;
  localparam logic [6:0] EV_EHI = 7'h40;
  logic        clk, rst, fpu_present, fpu_multithread, dsp_present, tlb_present, compressed_present;
  logic        vproc_config_enable, other_thread_holds_cu1, reg_wr, reg_rd, reg_rvalid;
  logic        gstat_wr, gstat_dsp, gstat_fr, gstat_cee, entryhi_wr, halted, retire, retire_privileged;
  logic        spawn, suspend_dealloc, halt_event, halt_isa_mode, halt_in_delay_slot, load_bus_error, is_thr0;
  logic        thread_dsp_enable, thread_fp_reg_mode, thread_core_ext_enable, activated;
  logic        dyn_alloc_ok, irq_eligible, resume_isa, ll_cancel;
  logic [1:0]  gstat_priv, spawn_priv, thread_privilege;
  logic [3:0]  gstat_cu, thread_coproc_usable, vproc_affiliation, bnd;
  logic [7:0]  entryhi_asid, spawn_asid, thread_addr_space_id;
  logic [31:0] reg_wdata, reg_rdata, halt_next_pc, halt_branch_pc, resume_pc, w;
  logic [6:0]  ev;
  tcc_sel_t    reg_sel;
  tcc_run_t    run_state_in;
  integer      seed, fail_count, comparisons, i;
  assign {entryhi_wr, gstat_wr, load_bus_error, halt_event, suspend_dealloc, spawn, retire} = ev;
  // ************************************************************
  // design
  // ************************************************************
  tcc_regs DUT (.clk(clk), .rst(rst), .fpu_present(fpu_present), .fpu_multithread(fpu_multithread),
    .dsp_present(dsp_present), .tlb_present(tlb_present), .compressed_present(compressed_present),
    .is_thread0(is_thr0), .own_thread_id(TID), .vproc0_last_thread_input(bnd),
    .vproc_config_enable(vproc_config_enable), .other_thread_holds_cu1(other_thread_holds_cu1),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .gstat_wr(gstat_wr), .gstat_cu(gstat_cu), .gstat_dsp(gstat_dsp),
    .gstat_fr(gstat_fr), .gstat_cee(gstat_cee), .gstat_priv(gstat_priv), .entryhi_wr(entryhi_wr),
    .entryhi_asid(entryhi_asid), .halted(halted), .run_state_in(run_state_in), .retire(retire),
    .retire_privileged(retire_privileged), .spawn(spawn), .spawn_priv(spawn_priv), .spawn_asid(spawn_asid),
    .suspend_dealloc(suspend_dealloc), .halt_event(halt_event), .halt_next_pc(halt_next_pc),
    .halt_isa_mode(halt_isa_mode), .halt_in_delay_slot(halt_in_delay_slot), .halt_branch_pc(halt_branch_pc),
    .load_bus_error(load_bus_error), .thread_coproc_usable(thread_coproc_usable),
    .thread_dsp_enable(thread_dsp_enable), .thread_fp_reg_mode(thread_fp_reg_mode),
    .thread_core_ext_enable(thread_core_ext_enable), .thread_privilege(thread_privilege),
    .thread_addr_space_id(thread_addr_space_id), .vproc_affiliation(vproc_affiliation),
    .activated(activated), .dyn_alloc_ok(dyn_alloc_ok), .irq_eligible(irq_eligible),
    .resume_pc(resume_pc), .resume_isa(resume_isa), .ll_cancel(ll_cancel));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ************************************************************
  // expectations and bus tasks
  // ************************************************************
  function automatic logic [31:0] bind_exp(input logic thread_bus_error);
    return {3'h0, TID, 3'h0, thread_bus_error, 13'h0, (TID <= {4'h0, bnd}) ? 4'h0 : 4'h1};
  endfunction
  function automatic logic [31:0] stat_exp(input logic [31:0] d);
    return (d & 32'hFC12BCFF) | 32'h01800000;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input tcc_sel_t s, input logic [31:0] d);
    @(posedge clk);
    reg_sel   <= s;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    #1;
    chk("ll_cancel", {31'h0, ll_cancel}, {31'h0, s == SEL_RESTART});
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input tcc_sel_t s, input logic [31:0] e, input string nm);
    @(posedge clk);
    reg_sel <= s;
    reg_rd  <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({nm, "_valid"}, {31'h0, reg_rvalid}, 32'h1);
    chk(nm, reg_rdata, e);
  endtask
  task automatic pulse(input logic [6:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 7'h0;
  endtask
  task tally_and_finish;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    seed = 75867; fail_count = 0; comparisons = 0; rst = 1'b1; ev = 7'h0; is_thr0 = 1'b1; bnd = BND;
    fpu_present = 1'b1; fpu_multithread = 1'b1; dsp_present = 1'b1; tlb_present = 1'b1;
    compressed_present = 1'b1; vproc_config_enable = 1'b0; other_thread_holds_cu1 = 1'b0;
    reg_sel = SEL_NONE; reg_wr = 1'b0; reg_rd = 1'b0; reg_wdata = 32'h0; halted = 1'b0;
    gstat_cu = 4'h0; gstat_dsp = 1'b0; gstat_fr = 1'b0; gstat_cee = 1'b0; gstat_priv = 2'h0;
    entryhi_asid = 8'h00; run_state_in = RS_RUNNING; retire_privileged = 1'b0; spawn_priv = 2'h0;
    spawn_asid = 8'h00; halt_next_pc = 32'h0; halt_isa_mode = 1'b0; halt_in_delay_slot = 1'b0;
    halt_branch_pc = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdchk(SEL_STATUS, 32'h00002000, "status_reset");
    chk("irq_eligible", {31'h0, irq_eligible}, 32'h1);
    rdchk(SEL_BIND, bind_exp(1'b0), "bind_reset");
    rdchk(SEL_NONE, 32'h0, "none_read");
    wr(SEL_STATUS, 32'hFFFFFFFF);
    rdchk(SEL_STATUS, 32'hFC12BCFF, "status_ones");
    chk("cu_out", {28'h0, thread_coproc_usable}, 32'hF);
    chk("alloc_ok", {31'h0, dyn_alloc_ok}, 32'h1);
    chk("irq_exempt", {31'h0, irq_eligible}, 32'h0);
    wr(SEL_STATUS, 32'h0);
    wr(SEL_NONE, 32'hFFFFFFFF);
    rdchk(SEL_STATUS, 32'h0, "status_zero");
    fpu_present <= 1'b0; dsp_present <= 1'b0; tlb_present <= 1'b0;
    wr(SEL_STATUS, 32'hFFFFFFFF);
    rdchk(SEL_STATUS, 32'hD412BC00, "status_nofpu");
    wr(SEL_STATUS, 32'h0);
    fpu_present <= 1'b1; fpu_multithread <= 1'b0; other_thread_holds_cu1 <= 1'b1;
    wr(SEL_STATUS, 32'hFFFFFFFF);
    rdchk(SEL_STATUS, 32'hD412BC00, "status_single_fpu");
    fpu_multithread <= 1'b1; dsp_present <= 1'b1; tlb_present <= 1'b1; other_thread_holds_cu1 <= 1'b0;
    wr(SEL_STATUS, 32'h0);
    gstat_cu <= 4'hA; gstat_dsp <= 1'b1; gstat_fr <= 1'b1; gstat_cee <= 1'b1; gstat_priv <= 2'h2;
    entryhi_asid <= 8'h5A;
    pulse(EV_GST | EV_EHI);
    rdchk(SEL_STATUS, 32'hAC02105A, "global_view");
    chk("priv_out", {30'h0, thread_privilege}, 32'h2);
    chk("state_out", {16'h0, thread_dsp_enable, thread_fp_reg_mode, thread_core_ext_enable,
      activated, vproc_affiliation, thread_addr_space_id}, 32'h0000E15A);
    wr(SEL_STATUS, 32'h0);
    retire_privileged <= 1'b1;
    pulse(EV_RET);
    rdchk(SEL_STATUS, 32'h0, "dirty_privileged");
    retire_privileged <= 1'b0;
    pulse(EV_RET);
    rdchk(SEL_STATUS, 32'h00100000, "dirty_set");
    wr(SEL_STATUS, 32'h0);
    spawn_priv <= 2'h1; spawn_asid <= 8'h33;
    pulse(EV_SPN);
    rdchk(SEL_STATUS, 32'h0, "spawn_no_alloc");
    wr(SEL_STATUS, 32'h00008000);
    pulse(EV_SPN);
    rdchk(SEL_STATUS, 32'h0010A833, "spawn_alloc");
    pulse(EV_SUS);
    rdchk(SEL_STATUS, 32'h00108833, "suspend_dealloc");
    pulse(EV_BUS);
    rdchk(SEL_BIND, bind_exp(1'b1), "bus_error");
    wr(SEL_BIND, 32'hFFFFFFFF);
    rdchk(SEL_BIND, bind_exp(1'b1), "bind_locked");
    vproc_config_enable <= 1'b1;
    wr(SEL_BIND, 32'h0);
    rdchk(SEL_BIND, {3'h0, TID, 21'h0}, "bind_config");
    wr(SEL_STATUS, 32'h0);
    run_state_in <= RS_GATING;
    repeat (2) @(posedge clk);
    halted <= 1'b1; run_state_in <= RS_RUNNING; halt_in_delay_slot <= 1'b1; halt_isa_mode <= 1'b1;
    halt_branch_pc <= 32'h80001234; halt_next_pc <= 32'h80001238;
    pulse(EV_HLT);
    rdchk(SEL_RESTART, 32'h80001235, "halt_slot");
    rdchk(SEL_STATUS, 32'h01A00000, "slot_flag_set");
    chk("resume_pc", resume_pc, 32'h80001234);
    chk("resume_isa", {31'h0, resume_isa}, 32'h1);
    halt_in_delay_slot <= 1'b0; halt_isa_mode <= 1'b0;
    pulse(EV_HLT);
    rdchk(SEL_RESTART, 32'h80001238, "halt_no_slot");
    rdchk(SEL_STATUS, 32'h01800000, "slot_flag_halt");
    halt_in_delay_slot <= 1'b1;
    pulse(EV_HLT);
    wr(SEL_RESTART, 32'h12345671);
    rdchk(SEL_STATUS, 32'h01800000, "slot_flag_write");
    compressed_present <= 1'b0;
    @(posedge clk);
    chk("resume_isa_off", {31'h0, resume_isa}, 32'h0);
    compressed_present <= 1'b1;
    for (i = 0; i < 40; i++) begin
      w = $random(seed);
      wr(SEL_RESTART, w);
      rdchk(SEL_RESTART, w, "restart_rand");
      chk("resume_pc_rand", resume_pc, {w[31:1], 1'b0});
      chk("resume_isa_rand", {31'h0, resume_isa}, {31'h0, w[0]});
      wr(SEL_STATUS, w);
      rdchk(SEL_STATUS, stat_exp(w), "status_rand");
      chk("halted_alloc", {31'h0, dyn_alloc_ok}, 32'h0);
      chk("halted_irq", {31'h0, irq_eligible}, 32'h0);
    end
    is_thr0 <= 1'b0; bnd <= 4'h7; rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdchk(SEL_STATUS, 32'h0, "status_rereset");
    rdchk(SEL_BIND, bind_exp(1'b0), "bind_rereset");
    chk("irq_rereset", {31'h0, irq_eligible}, 32'h0);
    tally_and_finish;
  end
  // ************************************************************
  // watchdog
  // ************************************************************
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    tally_and_finish;
  end
endmodule
